//--- design/acc_op_decode.sv
// Purpose: Classify one instruction word into an operation
// Assumes: Word is stable while valid
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
module acc_op_decode (
	input  wire logic [15:0]         instr_i,
	output var acc_exec_pkg::op_t    op_o
);
	always_comb begin
		op_o = acc_exec_pkg::OP_NONE;
		if (instr_i == acc_exec_pkg::TRAP_OPCODE) begin
			op_o = acc_exec_pkg::OP_TRAP;
		end else if (instr_i[15:8] == acc_exec_pkg::SHORT_IMM_TOP) begin
			// Clear is short load of zero
			op_o = acc_exec_pkg::OP_LOAD_IMM;
		end else if (instr_i[15:12] == acc_exec_pkg::XOR_IMM_TOP && instr_i[7:4] == acc_exec_pkg::XOR_IMM_MID
				&& instr_i[3:0] == acc_exec_pkg::XOR_IMM_LOW) begin
			op_o = acc_exec_pkg::OP_XOR_IMM;
		end else if (instr_i[15:9] == acc_exec_pkg::XOR_MEM_TOP) begin
			op_o = acc_exec_pkg::OP_XOR_MEM;
		end else if (instr_i[15:9] == acc_exec_pkg::LOAD_HIGH_TOP) begin
			op_o = instr_i[8] ? acc_exec_pkg::OP_LOAD_LOW : acc_exec_pkg::OP_LOAD_HIGH;
		end else if (instr_i[15:9] == acc_exec_pkg::LOAD_ROUND_TOP) begin
			op_o = acc_exec_pkg::OP_LOAD_RND;
		end
	end
endmodule
`default_nettype wire

//--- design/dsp_acc_load_xor_trap_exec.sv
// Purpose: Executes trap, XOR, clear, zero-fill and rounding loads on the accumulator
// Assumes: Decode path holds INSTR_I and the second word until ready
// Notes:   Stack itself lives outside; push and pop are strobes
//          Requests while a trap runs are dropped, not queued
//          Destination code 3 runs like on-chip ROM
//
// How it works
// - Trap loads program counter with 30
// - Trap pushes program counter plus one
// - Return pops stack into program counter
// - Trap takes 2/3/more cycles by destination
// - Immediate XOR shifts constant into accumulator
// - Bits outside shifted constant stay unchanged
// - Immediate XOR never changes accumulator MSB
// - Clear sets accumulator to zero
// - Clear decodes as short load zero
// - Low load copies word into low half
// - Low load clears upper half
// - Low load treats word as unsigned
// - Low load ignores sign-extension mode
`timescale 1ns/1ps
`default_nettype none
module dsp_acc_load_xor_trap_exec (
	input  wire logic        CLK_I,
	input  wire logic        RSTN_I,
	input  wire logic        CE_I,
	input  wire logic        INSTR_VALID_I,
	input  wire logic [15:0] INSTR_I,
	input  wire logic [15:0] SECOND_WORD_I,
	input  wire logic [15:0] DATA_I,
	input  wire logic [15:0] PC_I,
	input  wire logic        RETURN_I,
	input  wire logic [15:0] STACK_TOP_I,
	input  wire logic [1:0]  DEST_KIND_I,
	input  wire logic        EXT_READY_I,
	input  wire logic        SIGN_EXTEND_MODE_I,
	output logic             READY_O,
	output logic [31:0]      ACC_O,
	output logic [15:0]      PC_O,
	output logic             PC_LOAD_O,
	output logic             PUSH_O,
	output logic [15:0]      PUSH_DATA_O,
	output logic             POP_O
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_EXT  = 2'b10
	} state_t;

	typedef struct packed {
		state_t      st;
		logic [1:0]  cnt;
		logic [31:0] acc;
		logic [15:0] pc;
		logic        pc_load;
		logic        push;
		logic [15:0] push_data;
		logic        pop;
	} regs_t;

	// Reset image; pulses must start low
	localparam regs_t RESET_STATE = '{
		st:        ST_IDLE,
		cnt:       2'h0,
		acc:       acc_exec_pkg::ACC_RESET,
		pc:        acc_exec_pkg::PC_RESET,
		pc_load:   1'b0,
		push:      1'b0,
		push_data: acc_exec_pkg::PC_RESET,
		pop:       1'b0
	};

	regs_t             q;
	regs_t             d;
	acc_exec_pkg::op_t op;
	logic [46:0]       shifted;
	logic [31:0]       xor_mask;
	logic              sx_unused;
	logic [3:0]        shift_amt;
	logic [1:0]        trap_cycles;
	logic              trap_last;
	logic              trap_ext;

	acc_op_decode u_dec (
		.instr_i (INSTR_I),
		.op_o    (op)
	);

	// Sign mode deliberately ignored by every operation here
	assign sx_unused = SIGN_EXTEND_MODE_I;

	assign shift_amt = INSTR_I[acc_exec_pkg::SHIFT_MSB:acc_exec_pkg::SHIFT_LSB];
	// Wide enough that no constant bit is lost
	assign shifted   = {31'h0000_0000, SECOND_WORD_I} << shift_amt;
	// MSB masked off for any shift
	assign xor_mask = {1'b0, shifted[30:0]};

	always_comb begin
		unique case (DEST_KIND_I)
			acc_exec_pkg::DEST_RAM: begin
				trap_cycles = acc_exec_pkg::TRAP_CYC_RAM;
			end
			acc_exec_pkg::DEST_ROM: begin
				trap_cycles = acc_exec_pkg::TRAP_CYC_ROM;
			end
			acc_exec_pkg::DEST_EXT: begin
				// External adds its memory wait after this part
				trap_cycles = acc_exec_pkg::TRAP_CYC_ROM;
			end
			default: begin
				// Unused code runs like ROM
				trap_cycles = acc_exec_pkg::TRAP_CYC_ROM;
			end
		endcase
	end
	// Counter starts at one on the trap edge itself
	assign trap_last = (q.cnt + 2'h1) >= trap_cycles;
	assign trap_ext  = (DEST_KIND_I == acc_exec_pkg::DEST_EXT);

	// Idle takes one word per enabled edge, a return first
	// Wait counts the fixed part of a trap, ext the memory wait
	always_comb begin
		d = q;
		d.pc_load = 1'b0;
		d.push    = 1'b0;
		d.pop     = 1'b0;
		unique case (q.st)
			ST_IDLE: begin
				if (RETURN_I) begin
					// Pop return address to program counter
					d.pop     = 1'b1;
					d.pc      = STACK_TOP_I;
					d.pc_load = 1'b1;
				end else if (INSTR_VALID_I) begin
					unique case (op)
						acc_exec_pkg::OP_TRAP: begin
							d.push      = 1'b1;
							d.push_data = PC_I + 16'h0001;
							d.cnt       = acc_exec_pkg::TRAP_CYC_FIRST;
							d.st        = ST_WAIT;
						end
						acc_exec_pkg::OP_XOR_IMM: begin
							// Zeros outside the constant leave bits
							d.acc = q.acc ^ xor_mask;
						end
						acc_exec_pkg::OP_XOR_MEM: begin
							d.acc = {q.acc[31:16], q.acc[15:0] ^ DATA_I};
						end
						acc_exec_pkg::OP_LOAD_IMM: begin
							d.acc = {24'h00_0000, INSTR_I[7:0]};
						end
						acc_exec_pkg::OP_LOAD_HIGH: begin
							d.acc = {DATA_I, 16'h0000};
						end
						acc_exec_pkg::OP_LOAD_RND: begin
							d.acc = {DATA_I, acc_exec_pkg::ROUND_HALF};
						end
						acc_exec_pkg::OP_LOAD_LOW: begin
							d.acc = {16'h0000, DATA_I};
						end
						acc_exec_pkg::OP_NONE: begin
							// Unknown words leave state alone
							d.acc = q.acc;
						end
					endcase
				end
			end
			ST_WAIT: begin
				if (!trap_last) begin
					d.cnt = q.cnt + 2'h1;
				end else if (trap_ext) begin
					// Fixed part done; now wait on memory
					d.st = ST_EXT;
				end else begin
					d.pc      = acc_exec_pkg::TRAP_VECTOR;
					d.pc_load = 1'b1;
					d.st      = ST_IDLE;
				end
			end
			ST_EXT: begin
				// External destination waits for memory
				if (EXT_READY_I) begin
					d.pc      = acc_exec_pkg::TRAP_VECTOR;
					d.pc_load = 1'b1;
					d.st      = ST_IDLE;
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			q <= RESET_STATE;
		end else if (CE_I) begin
			q <= d;
		end
	end

	// Ready from state alone, so back-to-back words need no bubble
	assign READY_O     = (q.st == ST_IDLE);
	// Pulses are registered so they line up with PC_O
	assign ACC_O       = q.acc;
	assign PC_O        = q.pc;
	assign PC_LOAD_O   = q.pc_load;
	assign PUSH_O      = q.push;
	assign PUSH_DATA_O = q.push_data;
	assign POP_O       = q.pop;
endmodule
`default_nettype wire

//--- pkg/acc_exec_pkg.sv
// Purpose: Constants for the accumulator/trap execution block
// Assumes: 16-bit opcodes, 32-bit accumulator, 16-bit program counter
// Notes:   Opcode patterns are the fixed bits that select each operation, upper bits for most, low bits too for trap and immediate XOR
package acc_exec_pkg;
	localparam int          ACC_W            = 32;
	localparam int          PC_W             = 16;
	localparam int          SHIFT_LSB        = 8;
	localparam int          SHIFT_MSB        = 11;
	localparam int          HALF_W           = 16;
	localparam logic [15:0] TRAP_OPCODE      = 16'hCE1E;
	localparam logic [15:0] TRAP_VECTOR      = 16'h001E;
	localparam logic [15:0] CLEAR_OPCODE     = 16'hCA00;
	localparam logic [7:0]  SHORT_IMM_TOP    = 8'hCA;
	localparam logic [3:0]  XOR_IMM_TOP      = 4'hD;
	localparam logic [3:0]  XOR_IMM_LOW      = 4'hE;
	localparam logic [3:0]  XOR_IMM_MID      = 4'h0;
	localparam logic [6:0]  XOR_MEM_TOP      = 7'h26;
	localparam logic [6:0]  LOAD_HIGH_TOP    = 7'h20;
	localparam logic [6:0]  LOAD_LOW_TOP     = 7'h20;
	localparam logic [6:0]  LOAD_ROUND_TOP   = 7'h3D;
	localparam logic [15:0] ROUND_HALF       = 16'h8000;
	localparam logic [31:0] ACC_RESET        = 32'h0000_0000;
	localparam logic [15:0] PC_RESET         = 16'h0000;
	localparam logic [1:0]  TRAP_CYC_RAM     = 2'h2;
	localparam logic [1:0]  TRAP_CYC_ROM     = 2'h3;
	localparam logic [1:0]  TRAP_CYC_FIRST   = 2'h1;
	localparam logic [1:0]  DEST_RAM         = 2'h0;
	localparam logic [1:0]  DEST_ROM         = 2'h1;
	localparam logic [1:0]  DEST_EXT         = 2'h2;
	typedef enum logic [2:0] {
		OP_NONE      = 3'b000,
		OP_TRAP      = 3'b001,
		OP_XOR_IMM   = 3'b010,
		OP_XOR_MEM   = 3'b011,
		OP_LOAD_IMM  = 3'b100,
		OP_LOAD_HIGH = 3'b101,
		OP_LOAD_RND  = 3'b110,
		OP_LOAD_LOW  = 3'b111
	} op_t;
endpackage

//--- testbench/acc_exec_chk.sv
// Purpose: Port-level checks for the accumulator/trap block
// Assumes: CE_I stays high while a trap runs
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module acc_exec_chk (
	input wire logic        CLK_I,
	input wire logic        RSTN_I,
	input wire logic        CE_I,
	input wire logic        INSTR_VALID_I,
	input wire logic [15:0] INSTR_I,
	input wire logic [15:0] SECOND_WORD_I,
	input wire logic [15:0] DATA_I,
	input wire logic [15:0] PC_I,
	input wire logic        RETURN_I,
	input wire logic [15:0] STACK_TOP_I,
	input wire logic [1:0]  DEST_KIND_I,
	input wire logic        READY_O,
	input wire logic [31:0] ACC_O,
	input wire logic [15:0] PC_O,
	input wire logic        PC_LOAD_O,
	input wire logic        PUSH_O,
	input wire logic [15:0] PUSH_DATA_O,
	input wire logic        POP_O
);
	logic        go;
	logic        xi;
	logic [31:0] k;
	assign go = CE_I && READY_O && INSTR_VALID_I && !RETURN_I;
	assign xi = go && INSTR_I[15:12] == 4'hD && INSTR_I[7:0] == 8'h0E;
	// Top bit masked: immediate never reaches it
	assign k = ({16'h0000, SECOND_WORD_I} << INSTR_I[11:8]) & 32'h7FFF_FFFF;
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	sequence trap_go;
		go && INSTR_I == 16'hCE1E;
	endsequence
	push_ret_a: assert property (trap_go |=> PUSH_O && PUSH_DATA_O == $past(PC_I) + 16'h0001)
		else $error("bad push");
	vec_ram_a: assert property (trap_go ##0 DEST_KIND_I == 2'h0 ##1 CE_I |=> PC_LOAD_O && PC_O == 16'h001E)
		else $error("bad ram trap");
	vec_rom_a: assert property (trap_go ##0 DEST_KIND_I == 2'h1 ##1 CE_I [*2] |-> !PC_LOAD_O ##1 PC_LOAD_O)
		else $error("bad rom trap");
	ret_pop_a: assert property (CE_I && READY_O && RETURN_I |=> POP_O && PC_O == $past(STACK_TOP_I))
		else $error("bad return");
	xor_imm_a: assert property (xi |=> ACC_O == ($past(ACC_O) ^ $past(k)))
		else $error("bad xor");
	ld_low_a: assert property (go && INSTR_I[15:8] == 8'h41 |=> ACC_O == {16'h0000, $past(DATA_I)})
		else $error("bad low load");
	ld_high_a: assert property (go && INSTR_I[15:8] == 8'h40 |=> ACC_O == {$past(DATA_I), 16'h0000})
		else $error("bad high load");
	clr_acc_a: assert property (go && INSTR_I[15:8] == 8'hCA |=> ACC_O == {24'h00_0000, $past(INSTR_I[7:0])})
		else $error("bad clear");
	ld_rnd_a: assert property (go && INSTR_I[15:9] == 7'h3D |=> ACC_O == {$past(DATA_I), 16'h8000})
		else $error("bad round load");
	ce_hold_a: assert property (!CE_I |=> $stable(ACC_O) && $stable(PC_O))
		else $error("bad freeze");
endmodule
bind dsp_acc_load_xor_trap_exec acc_exec_chk u_chk (.*);
`default_nettype wire

//--- testbench/dsp_acc_load_xor_trap_exec_tb.sv
// Purpose: Random and corner tests of the accumulator/trap block
// Assumes: CE_I held high during traps; op drops it at random
// Notes:   External trap end waits on EXT_READY_I
`timescale 1ns/1ps
`default_nettype none
module dsp_acc_load_xor_trap_exec_tb;
	logic        CLK_I = 0, RSTN_I = 0, CE_I = 1, INSTR_VALID_I = 0, RETURN_I = 0, EXT_READY_I = 0;
	logic        SIGN_EXTEND_MODE_I = 0, READY_O, PC_LOAD_O, PUSH_O, POP_O;
	logic [1:0]  DEST_KIND_I = 0;
	logic [15:0] INSTR_I = 0, SECOND_WORD_I = 0, DATA_I = 0, PC_I = 0, STACK_TOP_I = 0, PC_O, PUSH_DATA_O;
	logic [31:0] ACC_O, ea = 0;
	int          bad_count = 0, comparisons = 0, cyc = 0, n;
	logic [15:0] ops [7] = '{16'hCA00, 16'hD00E, 16'h4C00, 16'h4000, 16'h4100, 16'h7A00, 16'hCA00};
	logic [15:0] msk [7] = '{16'h00FF, 16'h0F00, 16'h01FF, 16'h00FF, 16'h00FF, 16'h01FF, 16'h0000};
	dsp_acc_load_xor_trap_exec u_dut (.CLK_I, .RSTN_I, .CE_I, .INSTR_VALID_I, .INSTR_I, .SECOND_WORD_I, .DATA_I,
		.PC_I, .RETURN_I, .STACK_TOP_I, .DEST_KIND_I, .EXT_READY_I, .SIGN_EXTEND_MODE_I, .READY_O, .ACC_O,
		.PC_O, .PC_LOAD_O, .PUSH_O, .PUSH_DATA_O, .POP_O);
	always #50 CLK_I = ~CLK_I;
	task automatic chk(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge CLK_I) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			bad_count++;
			print_verdict();
		end
	end
	function automatic logic [31:0] nx(input logic [31:0] a, input logic [15:0] i, s, d);
		logic [31:0] k;
		k = {16'h0000, s} << i[11:8];
		if (i[15:8] == 8'hCA) return {24'h00_0000, i[7:0]};
		if (i[15:12] == 4'hD && i[7:0] == 8'h0E) return a ^ {1'b0, k[30:0]};
		if (i[15:9] == 7'h26) return a ^ {16'h0000, d};
		if (i[15:8] == 8'h40) return {d, 16'h0000};
		if (i[15:8] == 8'h41) return {16'h0000, d};
		if (i[15:9] == 7'h3D) return {d, 16'h8000};
		return a;
	endfunction
	task automatic op(input logic [15:0] i, s, d);
		INSTR_VALID_I = 1;
		INSTR_I = i;
		SECOND_WORD_I = s;
		DATA_I = d;
		SIGN_EXTEND_MODE_I = 1'($urandom);
		// Now and then a frozen edge; state must hold
		CE_I = ($urandom_range(7) != 0);
		if (CE_I) ea = nx(ea, i, s, d);
		@(negedge CLK_I);
		chk(ACC_O, ea);
	endtask
	task automatic trap(input logic [1:0] k);
		CE_I = 1;
		INSTR_VALID_I = 1;
		INSTR_I = 16'hCE1E;
		DEST_KIND_I = k;
		PC_I = 16'($urandom);
		@(negedge CLK_I);
		// A clear offered while busy must be ignored
		INSTR_I = 16'hCA00;
		chk({PUSH_O, READY_O, PUSH_DATA_O}, {2'b10, PC_I + 16'h0001});
		for (n = 1; PC_LOAD_O !== 1 && n < 20; n++) begin
			EXT_READY_I = (n == 4);
			@(negedge CLK_I);
		end
		INSTR_VALID_I = 0;
		EXT_READY_I = 0;
		chk(PC_O, 16'h001E);
		chk(ACC_O, ea);
		if (k < 2) chk(n, k + 2);
		else chk(n, 5);
		RETURN_I = 1;
		STACK_TOP_I = PC_I + 16'h0001;
		@(negedge CLK_I);
		RETURN_I = 0;
		chk({POP_O, PC_LOAD_O, PC_O}, {2'b11, STACK_TOP_I});
	endtask
	initial begin
		n = $urandom(32'h543a_c99d);
		repeat (5) @(negedge CLK_I);
		chk({READY_O, PUSH_O, POP_O, PC_LOAD_O, PC_O, 12'h000}, 32'h8000_0000);
		chk(ACC_O, 32'h0000_0000);
		RSTN_I = 1;
		for (int j = 0; j < 3; j++) trap(2'(j));
		op(16'hDF0E, 16'hFFFF, 16'h0000);
		op(16'h41A5, 16'h0000, 16'hFFFF);
		for (int j = 0; j < 400; j++) begin
			n = $urandom_range(6);
			op(ops[n] | (msk[n] & 16'($urandom)), 16'($urandom), 16'($urandom));
		end
		print_verdict();
	end
endmodule
`default_nettype wire
